// ==== shared/otp_prog_regs.vh ====
// Purpose: constants of the supply-line programmer: offsets, fields, resets, timing
// Assumes: 125 MHz system clock, 8-bit supply code at 0.1 V per step
// Notes:   definitions only
`ifndef OTP_PROG_REGS_VH
`define OTP_PROG_REGS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OTP_REG_CTRL            8'h00
`define OTP_REG_STATUS          8'h04
`define OTP_REG_FUSE            8'h08
`define OTP_REG_FIELD           8'h0c
`define OTP_REG_THRESH          8'h10

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define OTP_CTRL_OUTEN_BIT      0
`define OTP_CTRL_RESET          1'h1
`define OTP_STAT_STATE_LSB      0
`define OTP_STAT_LOCK_BIT       2
`define OTP_STAT_ON_BIT         3
`define OTP_STAT_LEVEL_LSB      4
`define OTP_STAT_TEMP_LSB       8
`define OTP_STAT_MIDS_LSB       16
`define OTP_FUSE_LOCK_BIT       8
`define OTP_THRESH_REL_LSB      16

// ----------------------------------------------------------------------------
// supply level bands (code = volts * 10)
// ----------------------------------------------------------------------------
`define OTP_LVL_FLOOR_CODE      8'h2d
`define OTP_LVL_MID_CODE        8'h48
`define OTP_LVL_HIGH_CODE       8'h9b
`define OTP_LVL_DROP            2'h0
`define OTP_LVL_LOW             2'h1
`define OTP_LVL_MID             2'h2
`define OTP_LVL_HIGH            2'h3

// ----------------------------------------------------------------------------
// protocol counts and timing
// ----------------------------------------------------------------------------
`define OTP_ENABLE_MIN_MIDS     4'h7
`define OTP_LOCK_SELECT         6'h07
`define OTP_CLK_PERIOD_NS       8
`define OTP_INTER_BIT_OFF_TIME_NS 20000
`define OTP_BIT_ON_TIME_NS      20000
`define OTP_BURN_PULSE_TIME_NS  100000
`define OTP_OFF_CYCLES  ((`OTP_INTER_BIT_OFF_TIME_NS + `OTP_CLK_PERIOD_NS - 1) / `OTP_CLK_PERIOD_NS)
`define OTP_ON_CYCLES   ((`OTP_BIT_ON_TIME_NS + `OTP_CLK_PERIOD_NS - 1) / `OTP_CLK_PERIOD_NS)
`define OTP_BURN_CYCLES ((`OTP_BURN_PULSE_TIME_NS + `OTP_CLK_PERIOD_NS - 1) / `OTP_CLK_PERIOD_NS)

`endif

// ==== rtl/otp_fuse_bank.v ====
// Purpose: one-time fuse store for the six address bits and the lock
// Assumes: burn strobes come from the protocol engine, one cycle each
// Notes:   srst models a blank part at power-up; nothing else clears a fuse
`timescale 1ns/100ps
module otp_fuse_bank
(
    input  wire       clk_sys,    // system clock
    input  wire       srst,       // sync reset, high
    input  wire       burnBit,    // pulse: commit one address bit
    input  wire [2:0] burnIndex,  // bit position 0..5
    input  wire       burnLock,   // pulse: commit the lock
    output reg  [5:0] fuseCode,   // burned address code
    output reg        fuseLock    // lock burned
);

    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            fuseCode <= 6'h00;
            fuseLock <= 1'h0;
        end
        else if (!fuseLock)
        begin
            // bits only ever go to one: a burned fuse cannot revert
            if (burnBit && (burnIndex < 3'h6))
                fuseCode <= fuseCode | (6'h01 << burnIndex);
            if (burnLock)
                fuseLock <= 1'h1;
        end
    end

endmodule

// ==== rtl/supply_pulse_classifier.v ====
// Purpose: sort supply samples into bands and measure pulse widths
// Assumes: supplyCode is from an on-chip converter on clk_sys
// Notes:   a pulse is any excursion above the low band; its kind is its highest band
`timescale 1ns/100ps
`include "otp_prog_regs.vh"
module supply_pulse_classifier
#(
    parameter CNT_W       = 16,
    parameter OFF_CYCLES  = `OTP_OFF_CYCLES,
    parameter ON_CYCLES   = `OTP_ON_CYCLES,
    parameter BURN_CYCLES = `OTP_BURN_CYCLES
)
(
    input  wire       clk_sys,    // system clock
    input  wire       srst,       // sync reset, high
    input  wire [7:0] supplyCode, // sampled supply voltage
    output reg  [1:0] level,      // current band
    output wire       dropout,    // supply under floor, level
    output reg        pulseEnd,   // pulse: pulse back to low band
    output reg  [1:0] pulseKind,  // band of ended pulse
    output reg        pulseOk,    // ended pulse long enough after a long gap
    output reg        wideHit     // pulse: high pulse just reached burn width
);

    reg [CNT_W-1:0] onCnt;
    reg [CNT_W-1:0] offCnt;
    reg             gapOk;
    reg [1:0]       peak;
    reg [1:0]       levelNext;

    // ------------------------------------------------------------------------
    // band decode
    // ------------------------------------------------------------------------
    always @*
    begin
        if (supplyCode < `OTP_LVL_FLOOR_CODE)
            levelNext = `OTP_LVL_DROP;
        else if (supplyCode >= `OTP_LVL_HIGH_CODE)
            levelNext = `OTP_LVL_HIGH;
        else if (supplyCode >= `OTP_LVL_MID_CODE)
            levelNext = `OTP_LVL_MID;
        else
            levelNext = `OTP_LVL_LOW;
    end

    assign dropout = (level == `OTP_LVL_DROP);

    // ------------------------------------------------------------------------
    // width measurement
    // ------------------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            level     <= `OTP_LVL_LOW;
            onCnt     <= {CNT_W{1'b0}};
            offCnt    <= {CNT_W{1'b0}};
            gapOk     <= 1'h1;
            peak      <= `OTP_LVL_LOW;
            pulseEnd  <= 1'h0;
            pulseKind <= `OTP_LVL_LOW;
            pulseOk   <= 1'h0;
            wideHit   <= 1'h0;
        end
        else
        begin
            level    <= levelNext;
            pulseEnd <= 1'h0;
            wideHit  <= 1'h0;
            if (level == `OTP_LVL_DROP)
            begin
                // a dropout voids any pulse in flight
                onCnt  <= {CNT_W{1'b0}};
                offCnt <= {CNT_W{1'b0}};
                gapOk  <= 1'h0;
                peak   <= `OTP_LVL_LOW;
            end
            else if (level == `OTP_LVL_LOW)
            begin
                if (peak != `OTP_LVL_LOW)
                begin
                    pulseEnd  <= 1'h1;
                    pulseKind <= peak;
                    pulseOk   <= gapOk && (onCnt >= ON_CYCLES[CNT_W-1:0]);
                    gapOk     <= 1'h0;
                    offCnt    <= {CNT_W{1'b0}};
                end
                else if (offCnt < OFF_CYCLES[CNT_W-1:0])
                    offCnt <= offCnt + 1'b1;
                else
                    gapOk <= 1'h1;
                peak  <= `OTP_LVL_LOW;
                onCnt <= {CNT_W{1'b0}};
            end
            else
            begin
                if (level > peak)
                    peak <= level;
                if (onCnt != {CNT_W{1'b1}})
                    onCnt <= onCnt + 1'b1;
                // fires once, mid-pulse, so the burn lands inside the wide pulse
                if (level == `OTP_LVL_HIGH && gapOk
                    && onCnt == BURN_CYCLES[CNT_W-1:0] - 1'b1)
                    wideHit <= 1'h1;
            end
        end
    end

endmodule

// ==== rtl/supply_line_otp_programmer.v ====
// Purpose: sensor switch with operate point programmed over the supply line
// Assumes: supply and field codes come from on-chip converters on clk_sys
// Notes:   registers over APB are for observation and output gating only
//
// Behaviour
// - supply pulses are the only programming path
// - enable needs high, seven+ mids, high
// - 64 operate points from a 6-bit code
// - stepped address applied temporarily to threshold
// - hysteresis constant for every address
// - burn only the one bits, one by one
// - commit only in wide high pulse, permanent
// - lock refuses any further programming
// - output turns on low above operate threshold
// - output turns off high below release threshold
// - output comes up off after power
`timescale 1ns/100ps
`include "otp_prog_regs.vh"
module supply_line_otp_programmer
#(
    parameter        CNT_W       = 16,
    parameter        FIELD_W     = 12,
    parameter        BURN_CYCLES = `OTP_BURN_CYCLES,
    parameter [11:0] OP_BASE     = 12'h1f4,
    parameter [11:0] OP_STEP     = 12'h00b,
    parameter [11:0] HYST        = 12'h014
)
(
    input  wire               clk_sys,     // system clock, 125 MHz
    input  wire               srst,        // sync reset, high
    input  wire [7:0]         supplyCode,  // supply voltage sample
    input  wire [FIELD_W-1:0] fieldCode,   // sensed field sample
    output reg                sensorOutData, // open-drain data, always 0
    output reg                sensorOutEnN,  // low while the pin sinks
    input  wire               psel,        // apb select
    input  wire               penable,     // apb enable
    input  wire               pwrite,      // apb write
    input  wire [7:0]         paddr,       // apb byte address
    input  wire [31:0]        pwdata,      // apb write data
    output reg  [31:0]        prdata,      // apb read data
    output wire               pready,      // apb ready
    output wire               pslverr      // apb error
);

    // ------------------------------------------------------------------------
    // states and helpers
    // ------------------------------------------------------------------------
    localparam [1:0] ST_IDLE    = 2'h0;
    localparam [1:0] ST_COUNT   = 2'h1;
    localparam [1:0] ST_ENABLED = 2'h2;

    function [FIELD_W-1:0] thresholdFor;
        input [5:0] addr;
        reg   [FIELD_W+6:0] sum;
        begin
            sum = {7'h00, OP_BASE[FIELD_W-1:0]} + addr * OP_STEP[FIELD_W-1:0];
            thresholdFor = sum[FIELD_W-1:0];
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr == `OTP_REG_CTRL) || (addr == `OTP_REG_STATUS)
                  || (addr == `OTP_REG_FUSE) || (addr == `OTP_REG_FIELD)
                  || (addr == `OTP_REG_THRESH);
        end
    endfunction

    // ------------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------------
    wire [1:0]         level;
    wire               dropout;
    wire               pulseEnd;
    wire [1:0]         pulseKind;
    wire               pulseOk;
    wire               wideHit;
    wire [5:0]         fuseCode;
    wire               fuseLock;
    reg  [1:0]         state_reg;
    reg  [1:0]         state_next;
    reg  [3:0]         mids_reg;
    reg  [3:0]         mids_next;
    reg  [5:0]         temp_reg;
    reg  [5:0]         temp_next;
    reg                burnBit;
    reg                burnLock;
    reg  [2:0]         burnIndex;
    reg                outOn_reg;
    reg                outEn_reg;
    wire [5:0]         activeAddr;
    wire [FIELD_W-1:0] operateLvl;
    wire [FIELD_W-1:0] releaseLvl;
    wire               apbSetup;
    wire               apbWrite;

    // ------------------------------------------------------------------------
    // supply front end and fuse store
    // ------------------------------------------------------------------------
    supply_pulse_classifier
    #(
        .CNT_W       (CNT_W),
        .OFF_CYCLES  (`OTP_OFF_CYCLES),
        .ON_CYCLES   (`OTP_ON_CYCLES),
        .BURN_CYCLES (BURN_CYCLES)
    )
    classifier
    (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .supplyCode (supplyCode),
        .level      (level),
        .dropout    (dropout),
        .pulseEnd   (pulseEnd),
        .pulseKind  (pulseKind),
        .pulseOk    (pulseOk),
        .wideHit    (wideHit)
    );

    otp_fuse_bank fuses
    (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .burnBit   (burnBit),
        .burnIndex (burnIndex),
        .burnLock  (burnLock),
        .fuseCode  (fuseCode),
        .fuseLock  (fuseLock)
    );

    // ------------------------------------------------------------------------
    // programming protocol
    // ------------------------------------------------------------------------
    // short pulses or short gaps mean noise: they void an unfinished enable
    always @*
    begin
        state_next = state_reg;
        mids_next  = mids_reg;
        temp_next  = temp_reg;
        burnBit    = 1'h0;
        burnLock   = 1'h0;
        burnIndex  = 3'h0;
        if (fuseLock)
        begin
            state_next = ST_IDLE;
            mids_next  = 4'h0;
            temp_next  = 6'h00;
        end
        else if (dropout)
        begin
            state_next = ST_IDLE;
            mids_next  = 4'h0;
            temp_next  = 6'h00;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (pulseEnd && pulseOk && pulseKind == `OTP_LVL_HIGH)
                    begin
                        state_next = ST_COUNT;
                        mids_next  = 4'h0;
                    end
                end
                ST_COUNT:
                begin
                    if (pulseEnd && !pulseOk)
                        state_next = ST_IDLE;
                    else if (pulseEnd && pulseKind == `OTP_LVL_MID)
                    begin
                        if (mids_reg != 4'hf)
                            mids_next = mids_reg + 4'h1;
                    end
                    else if (pulseEnd && pulseKind == `OTP_LVL_HIGH)
                    begin
                        mids_next = 4'h0;
                        if (mids_reg >= `OTP_ENABLE_MIN_MIDS)
                        begin
                            state_next = ST_ENABLED;
                            temp_next  = 6'h00;
                        end
                    end
                end
                ST_ENABLED:
                begin
                    // a burn commits at the moment the high pulse reaches burn width
                    if (wideHit)
                    begin
                        if (temp_reg >= 6'h01 && temp_reg <= 6'h06)
                        begin
                            burnBit   = 1'h1;
                            burnIndex = temp_reg[2:0] - 3'h1;
                        end
                        else if (temp_reg == `OTP_LOCK_SELECT)
                            burnLock = 1'h1;
                    end
                    if (pulseEnd && pulseOk && pulseKind == `OTP_LVL_MID)
                        temp_next = temp_reg + 6'h01;
                    else if (pulseEnd && pulseKind == `OTP_LVL_HIGH)
                        temp_next = 6'h00;
                end
                default:
                begin
                    state_next = ST_IDLE;
                    mids_next  = 4'h0;
                    temp_next  = 6'h00;
                end
            endcase
        end
    end

    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_reg <= ST_IDLE;
            mids_reg  <= 4'h0;
            temp_reg  <= 6'h00;
        end
        else
        begin
            state_reg <= state_next;
            mids_reg  <= mids_next;
            temp_reg  <= temp_next;
        end
    end

    // ------------------------------------------------------------------------
    // thresholds and output
    // ------------------------------------------------------------------------
    // while enabled the stepped address drives the threshold so the station
    // can watch the output switch; otherwise the burned code does
    assign activeAddr = (state_reg == ST_ENABLED) ? temp_reg : fuseCode;
    assign operateLvl = thresholdFor(activeAddr);
    assign releaseLvl = (operateLvl > HYST[FIELD_W-1:0])
                      ? operateLvl - HYST[FIELD_W-1:0]
                      : {FIELD_W{1'b0}};

    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            outOn_reg     <= 1'h0;
            sensorOutEnN  <= 1'h1;
            sensorOutData <= 1'h0;
        end
        else
        begin
            sensorOutData <= 1'h0;
            if (!outOn_reg && fieldCode > operateLvl)
                outOn_reg <= 1'h1;
            else if (outOn_reg && fieldCode < releaseLvl)
                outOn_reg <= 1'h0;
            // disabling the output only releases the pin; switching continues
            sensorOutEnN <= !(outOn_reg && outEn_reg);
        end
    end

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------
    // zero-wait: data is latched in setup so it comes from a flop in access
    assign pready   = 1'h1;
    assign pslverr  = psel && penable && !mapped(paddr);
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite;

    always @(posedge clk_sys)
    begin
        if (srst)
            outEn_reg <= `OTP_CTRL_RESET;
        else if (apbWrite && paddr == `OTP_REG_CTRL)
            outEn_reg <= pwdata[`OTP_CTRL_OUTEN_BIT];
    end

    always @(posedge clk_sys)
    begin
        if (srst)
            prdata <= 32'h00000000;
        else if (apbSetup)
        begin
            prdata <= 32'h00000000;
            case (paddr)
                `OTP_REG_CTRL:
                    prdata[`OTP_CTRL_OUTEN_BIT] <= outEn_reg;
                `OTP_REG_STATUS:
                begin
                    prdata[`OTP_STAT_STATE_LSB +: 2] <= state_reg;
                    prdata[`OTP_STAT_LOCK_BIT]       <= fuseLock;
                    prdata[`OTP_STAT_ON_BIT]         <= outOn_reg;
                    prdata[`OTP_STAT_LEVEL_LSB +: 2] <= level;
                    prdata[`OTP_STAT_TEMP_LSB +: 6]  <= temp_reg;
                    prdata[`OTP_STAT_MIDS_LSB +: 4]  <= mids_reg;
                end
                `OTP_REG_FUSE:
                begin
                    prdata[5:0]                <= fuseCode;
                    prdata[`OTP_FUSE_LOCK_BIT] <= fuseLock;
                end
                `OTP_REG_FIELD:
                    prdata[FIELD_W-1:0] <= fieldCode;
                `OTP_REG_THRESH:
                begin
                    prdata[FIELD_W-1:0]                   <= operateLvl;
                    prdata[`OTP_THRESH_REL_LSB +: FIELD_W] <= releaseLvl;
                end
                default:
                    prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// ==== verification/supply_line_otp_programmer_chk.sv ====
// Purpose: port-level checks of switching output and programming readback
// Assumes: fuse and threshold registers as mapped in the shared header
// Notes:   ctrlEn mirrors the output-enable bit from observed writes
`timescale 1ns/100ps
`include "otp_prog_regs.vh"
module supply_line_otp_programmer_chk
#(
    parameter        FIELD_W = 12,
    parameter [11:0] OP_BASE = 12'h1f4,
    parameter [11:0] OP_STEP = 12'h00b,
    parameter [11:0] HYST    = 12'h014
)
(
    input wire logic               clk_sys,       // system clock
    input wire logic               srst,          // sync reset
    input wire logic [FIELD_W-1:0] fieldCode,     // field sample
    input wire logic               sensorOutData, // pin data
    input wire logic               sensorOutEnN,  // pin sink enable
    input wire logic               psel,          // apb select
    input wire logic               penable,       // apb enable
    input wire logic               pwrite,        // apb write
    input wire logic [7:0]         paddr,         // apb address
    input wire logic [31:0]        pwdata,        // apb write data
    input wire logic [31:0]        prdata         // apb read data
);
    localparam int OP_MAX  = OP_BASE + 63 * OP_STEP;
    localparam int REL_MIN = OP_BASE - HYST;
    logic       ctrlEn;
    logic [5:0] fuseSeen;
    wire        rdAcc = psel & penable & ~pwrite;
    // ------------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            ctrlEn   <= 1'b1;
            fuseSeen <= 6'h00;
        end
        else
        begin
            if (psel && penable && pwrite && paddr == `OTP_REG_CTRL)
                ctrlEn <= pwdata[0];
            if (rdAcc && paddr == `OTP_REG_FUSE)
                fuseSeen <= prdata[5:0];
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence fieldHigh;
        (fieldCode > OP_MAX && ctrlEn) [*3];
    endsequence
    sequence fieldLow;
        (fieldCode < REL_MIN) [*3];
    endsequence
    a_sink_only: assert property (sensorOutData == 1'b0)
        else $error("output data not low");
    a_on_above: assert property (fieldHigh |-> !sensorOutEnN)
        else $error("output off above every operate point");
    a_off_below: assert property (fieldLow |-> sensorOutEnN)
        else $error("output on below every release point");
    a_on_cause: assert property ($fell(sensorOutEnN) |->
        $past(fieldCode) > OP_BASE || $past(fieldCode, 2) > OP_BASE)
        else $error("output turned on without field above operate");
    a_off_cause: assert property ($rose(sensorOutEnN) |->
        $past(fieldCode) < OP_MAX - HYST || $past(fieldCode, 2) < OP_MAX - HYST
        || !$past(ctrlEn) || !$past(ctrlEn, 2))
        else $error("output turned off without field below release");
    a_power_up_off: assert property ($fell(srst) |-> sensorOutEnN)
        else $error("output not off after power up");
    a_hyst_const: assert property ((rdAcc && paddr == `OTP_REG_THRESH) |->
        prdata[11:0] - prdata[27:16] == HYST)
        else $error("hysteresis differs from constant");
    a_op_grid: assert property ((rdAcc && paddr == `OTP_REG_THRESH) |->
        prdata[11:0] >= OP_BASE && prdata[11:0] <= OP_MAX
        && (prdata[11:0] - OP_BASE) % OP_STEP == 0)
        else $error("operate point off the 64 step grid");
    a_fuse_sticky: assert property ((rdAcc && paddr == `OTP_REG_FUSE) |->
        (prdata[5:0] & fuseSeen) == fuseSeen)
        else $error("burned address bit reverted");
endmodule
bind supply_line_otp_programmer supply_line_otp_programmer_chk #(.FIELD_W(FIELD_W),
    .OP_BASE(OP_BASE), .OP_STEP(OP_STEP), .HYST(HYST)) u_chk (.clk_sys(clk_sys),
    .srst(srst), .fieldCode(fieldCode), .sensorOutData(sensorOutData),
    .sensorOutEnN(sensorOutEnN), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata));

// ==== verification/prog_station.sv ====
// Purpose: programming station driving the supply line
// Assumes: tasks are entered just after a rising clock edge
// Notes:   supply never dips under the floor band while programming
`timescale 1ns/100ps
module prog_station
(
    input  wire logic       clk_sys,    // system clock
    output logic      [7:0] supplyCode  // supply level
);
    localparam logic [7:0] FLOOR = 8'h32;
    localparam logic [7:0] MID   = 8'h64;
    localparam logic [7:0] HIGH  = 8'he6;
    localparam int         ON    = 2501;
    localparam int         GAP   = 2504;
    initial supplyCode = FLOOR;
    // ON is the on-time count plus margin; the scaled burn count is hidden inside it
    task automatic pulse(input logic [7:0] lvl);
        supplyCode <= lvl;
        repeat (ON) @(posedge clk_sys);
        supplyCode <= FLOOR;
        repeat (GAP) @(posedge clk_sys);
    endtask
    task automatic enable();
        pulse(HIGH);
        repeat (7) pulse(MID);
        pulse(HIGH);
    endtask
    task automatic select(input int n);
        repeat (n) pulse(MID);
    endtask
    task automatic burn();
        pulse(HIGH);
    endtask
endmodule

// ==== verification/supply_line_otp_programmer_bench.sv ====
// Purpose: self-checking bench for the supply-line programmed switch
// Assumes: zero-wait apb slave, short burn count
// Notes:   one bit burned, then the lock, then a refused burn
`timescale 1ns/100ps
`include "otp_prog_regs.vh"
module supply_line_otp_programmer_bench;
    logic        clk_sys    = 1'b0;
    logic        srst       = 1'b1;
    logic [11:0] fieldCode  = 12'h000;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic [31:0] rdata;
    logic        errSeen;
    wire  [7:0]  supplyCode;
    wire  [31:0] prdata;
    wire         pready, pslverr, sensorOutData, sensorOutEnN;
    int          failures   = 0;
    int          n_checks   = 0;
    always #4 clk_sys = ~clk_sys;
    prog_station i_prog (.clk_sys(clk_sys), .supplyCode(supplyCode));
    supply_line_otp_programmer #(.BURN_CYCLES(40)) i_dut (.clk_sys(clk_sys), .srst(srst),
        .supplyCode(supplyCode), .fieldCode(fieldCode), .sensorOutData(sensorOutData),
        .sensorOutEnN(sensorOutEnN), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge clk_sys); k++; end while (pready !== 1'b1 && k < 16);
        rdata = prdata;
        errSeen = pslverr;
        if (k >= 16)
        begin
            failures++;
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic fld(input logic [11:0] v, input logic e);
        fieldCode <= v;
        repeat (4) @(posedge clk_sys);
        chk("out_en_n", {31'h0, sensorOutEnN}, {31'h0, e});
    endtask
    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        apb(0, `OTP_REG_CTRL, 0); chk("ctrl", rdata, 32'h1);
        apb(0, `OTP_REG_STATUS, 0); chk("status", rdata, 32'h10);
        apb(0, `OTP_REG_FUSE, 0); chk("fuse", rdata, 32'h0);
        apb(0, `OTP_REG_THRESH, 0); chk("thresh", rdata, 32'h01e0_01f4);
        apb(0, 8'h14, 0); chk("slverr", {31'h0, errSeen}, 32'h1);
        fld(12'h1f5, 1'b0);
        fld(12'h1ea, 1'b0);
        fld(12'h1df, 1'b1);
        fld(12'h4b1, 1'b0);
        fld(12'h258, 1'b0);
        apb(1, `OTP_REG_CTRL, 32'h0);
        fld(12'h258, 1'b1);
        apb(1, `OTP_REG_CTRL, 32'h1);
        fld(12'h000, 1'b1);
        i_prog.enable();
        apb(0, `OTP_REG_STATUS, 0); chk("enabled", {18'h0, rdata[13:0]}, 32'h12);
        i_prog.select(1);
        apb(0, `OTP_REG_STATUS, 0); chk("temp", {26'h0, rdata[13:8]}, 32'h1);
        apb(0, `OTP_REG_THRESH, 0); chk("thr_temp", rdata, 32'h01eb_01ff);
        fld(12'h1f9, 1'b1);
        fieldCode <= 12'h000;
        i_prog.burn();
        apb(0, `OTP_REG_FUSE, 0); chk("fuse_b0", rdata, 32'h1);
        i_prog.select(7);
        i_prog.burn();
        apb(0, `OTP_REG_FUSE, 0); chk("fuse_lock", rdata, 32'h101);
        apb(0, `OTP_REG_STATUS, 0); chk("lock", {31'h0, rdata[2]}, 32'h1);
        i_prog.burn();
        apb(0, `OTP_REG_FUSE, 0); chk("refused", rdata, 32'h101);
        apb(0, `OTP_REG_THRESH, 0); chk("thr_burned", rdata, 32'h01eb_01ff);
        fld(12'h1f9, 1'b1);
        fld(12'h200, 1'b0);
        results();
    end
endmodule
